/* File: hw/pirq_top.sv */
// prioritized interrupt controller with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "pirq_consts.svh"

// Summary of operation
// (R1) each source has a flag set by hardware, cleared only by software write
// (R2) a source with its enable clear never requests the core
// (R3) each source has a programmable three-bit priority, eight levels
// (R4) vector latch holds 7-bit vector number and 4-bit new level
// (R5) latched level equals programmed priority of the presented source
// (R6) flag, enable, priority positions follow vector order, line 0 at bit 0
// (R7) cpu level sits in alu status bits 7:5, software writable
// (R8) fourth cpu level bit in core control is read-only
// (R9) global control 1 holds nesting disable and trap flags
// (R10) global control 2 sets external line edges and alternate table use
// (R11) register set: two globals, six flag, six enable, priority, vector latch
// (R12) enable 1 bits 15,14,13,11,9: uart2 tx, rx, line 2, timer 4, ccp3
// (R13) enable 1 bits 4..0: line 1, pin change, comparator, collision, serial
// (R14) enable bit 1 enables, 0 disables, all reset to zero
// (R15) enable 1 bits 12, 10, 8-5 read zero and ignore writes
// (R16) small variants lack uart2, timer 4 and ccp3 enables
// (R17) highest enabled pending priority wins, low vector breaks ties, must beat cpu
module pirq_top #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // request sources
    input  wire logic [`PIRQ_NUM_SRC-1:0]   periph_req,
    input  wire logic [`PIRQ_NUM_EXT-1:0]   ext_line,
    input  wire logic [`PIRQ_NUM_TRAPS-1:0] trap_event,
    // processor core
    input  wire logic                       cpu_priority_msb,
    output pirq_pkg::pirq_core_t            core,
    // summary interrupt
    output logic                            irq
);

    // ************************************************************
    // implemented bit masks
    // ************************************************************
    localparam logic [15:0] EN1_MASK = SMALL_VARIANT ? `PIRQ_EN1_SMALL_MASK
                                                     : `PIRQ_EN1_FULL_MASK;
    localparam logic [`PIRQ_NUM_SRC-1:0] IMPL_MASK = {{4{`PIRQ_FULL_MASK}},
                                                      EN1_MASK,
                                                      `PIRQ_FULL_MASK};

    pirq_pkg::pirq_state_t s_reg;
    pirq_pkg::pirq_state_t s_next;

    logic                          wr_en;
    logic                          rd_setup;
    logic [5:0]                    widx;
    logic                          mapped;
    logic [`PIRQ_NUM_SRC-1:0]      set_vec;
    logic [`PIRQ_NUM_EXT-1:0]      ext_edge;
    logic [`PIRQ_NUM_SRC-1:0]      pending;
    logic [2:0]                    best_p;
    logic [6:0]                    best_v;
    logic                          found;
    logic [3:0]                    cpu_level;
    logic                          want_req;
    logic [`PIRQ_NUM_EV-1:0]       events;
    logic [31:0]                   rd_word;

    // ************************************************************
    // apb decode
    // ************************************************************
    assign widx     = paddr[7:2];
    assign mapped   = (paddr[11:8] == 4'h0) && (widx <= `PIRQ_IDX_IRQ_EN);
    assign pready   = psel & penable;
    assign pslverr  = pready & ~mapped;
    assign wr_en    = pready & pwrite & mapped;
    // read data is captured in the setup cycle so the access needs no wait
    assign rd_setup = psel & ~penable & ~pwrite;
    assign prdata   = s_reg.prdata;

    // ************************************************************
    // outputs toward core and software
    // ************************************************************
    assign core.req            = s_reg.core_req;
    assign core.vector_number  = s_reg.vector_number;
    assign core.latched_level  = s_reg.latched_level;
    assign core.alt_vector_sel = s_reg.alternate_vector_table; // [R10]
    assign irq                 = |(s_reg.irq_stat & s_reg.irq_en);
    assign cpu_level           = {cpu_priority_msb, s_reg.cpu_priority_level}; // [R8]

    // ************************************************************
    // external line edges
    // ************************************************************
    always_comb begin
        for (int i = 0; i < `PIRQ_NUM_EXT; i++) begin
            // polarity bit picks falling edge, otherwise rising
            ext_edge[i] = s_reg.ext_falling[i] ? (s_reg.ext_prev[i] & ~s_reg.ext_s2[i])
                                               : (~s_reg.ext_prev[i] & s_reg.ext_s2[i]); // [R10]
        end
    end

    always_comb begin
        set_vec                    = periph_req;
        set_vec[`PIRQ_VEC_EXT0]    = periph_req[`PIRQ_VEC_EXT0] | ext_edge[0]; // [R6]
        set_vec[`PIRQ_VEC_EXT1]    = periph_req[`PIRQ_VEC_EXT1] | ext_edge[1];
        set_vec[`PIRQ_VEC_EXT2]    = periph_req[`PIRQ_VEC_EXT2] | ext_edge[2];
        set_vec                    = set_vec & IMPL_MASK; // [R16]
    end

    // ************************************************************
    // arbitration
    // ************************************************************
    assign pending = s_reg.flags & s_reg.enables; // [R2]

    always_comb begin
        best_p = 3'h0;
        best_v = 7'h00;
        found  = 1'b0;
        // scan downward so an equal priority lets the lower vector win
        for (int i = `PIRQ_NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i] && (s_reg.prio[i] != 3'h0) && (s_reg.prio[i] >= best_p)) begin
                best_p = s_reg.prio[i]; // [R17]
                best_v = 7'(i);
                found  = 1'b1;
            end
        end
    end

    // nesting disable lets a request through only from the base level
    assign want_req = found && ({1'b0, best_p} > cpu_level) &&
                      (!s_reg.nesting_disable || (cpu_level == 4'h0)); // [R17] [R9]

    // ************************************************************
    // register read mux
    // ************************************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        if (widx == `PIRQ_IDX_GIC1) begin
            rd_word[`PIRQ_GIC1_NEST_BIT] = s_reg.nesting_disable; // [R9]
            rd_word[`PIRQ_GIC1_TRAP_LSB +: `PIRQ_NUM_TRAPS] = s_reg.trap_flags;
        end else if (widx == `PIRQ_IDX_GIC2) begin
            rd_word[`PIRQ_GIC2_ALT_BIT] = s_reg.alternate_vector_table; // [R10]
            rd_word[`PIRQ_NUM_EXT-1:0]  = s_reg.ext_falling;
        end else if (widx == `PIRQ_IDX_VLATCH) begin
            rd_word[6:0] = s_reg.vector_number; // [R4]
            rd_word[`PIRQ_VL_LVL_LSB +: 4] = s_reg.latched_level;
        end else if (widx == `PIRQ_IDX_ALU_STAT) begin
            rd_word[`PIRQ_ALU_IPL_LSB +: 3] = s_reg.cpu_priority_level; // [R7]
        end else if (widx == `PIRQ_IDX_CORE_CTRL) begin
            rd_word[`PIRQ_CORE_CPU_PRIORITY_MSB_BIT] = cpu_priority_msb; // [R8]
        end else if (widx == `PIRQ_IDX_IRQ_STAT) begin
            rd_word[`PIRQ_NUM_EV-1:0] = s_reg.irq_stat;
        end else if (widx == `PIRQ_IDX_IRQ_EN) begin
            rd_word[`PIRQ_NUM_EV-1:0] = s_reg.irq_en;
        end
        for (int r = 0; r < `PIRQ_NUM_FLAG_REGS; r++) begin
            if (widx == 6'(`PIRQ_IDX_FLAG0 + r)) begin
                rd_word[15:0] = s_reg.flags[16*r +: 16]; // [R11]
            end
            if (widx == 6'(`PIRQ_IDX_EN0 + r)) begin
                rd_word[15:0] = s_reg.enables[16*r +: 16]; // [R15]
            end
        end
        for (int r = 0; r < `PIRQ_NUM_PRIO_REGS; r++) begin
            if (widx == 6'(`PIRQ_IDX_PRIO0 + r)) begin
                for (int j = 0; j < `PIRQ_PRIO_PER_REG; j++) begin
                    rd_word[4*j +: 3] = s_reg.prio[`PIRQ_PRIO_PER_REG*r + j]; // [R6]
                end
            end
        end
        if (!mapped) begin
            rd_word = 32'h0000_0000;
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;

        // pins pass two flops before the edge detector sees them
        s_next.ext_s1   = ext_line;
        s_next.ext_s2   = s_reg.ext_s1;
        s_next.ext_prev = s_reg.ext_s2;

        if (rd_setup) begin
            s_next.prdata = rd_word;
        end

        if (wr_en) begin
            if (widx == `PIRQ_IDX_GIC1) begin
                s_next.nesting_disable = pwdata[`PIRQ_GIC1_NEST_BIT]; // [R9]
                s_next.trap_flags = pwdata[`PIRQ_GIC1_TRAP_LSB +: `PIRQ_NUM_TRAPS];
            end
            if (widx == `PIRQ_IDX_GIC2) begin
                s_next.alternate_vector_table = pwdata[`PIRQ_GIC2_ALT_BIT]; // [R10]
                s_next.ext_falling = pwdata[`PIRQ_NUM_EXT-1:0];
            end
            if (widx == `PIRQ_IDX_ALU_STAT) begin
                s_next.cpu_priority_level = pwdata[`PIRQ_ALU_IPL_LSB +: 3]; // [R7]
            end
            if (widx == `PIRQ_IDX_IRQ_EN) begin
                s_next.irq_en = pwdata[`PIRQ_NUM_EV-1:0];
            end
            for (int r = 0; r < `PIRQ_NUM_FLAG_REGS; r++) begin
                if (widx == 6'(`PIRQ_IDX_FLAG0 + r)) begin
                    s_next.flags[16*r +: 16] = pwdata[15:0]; // [R1]
                end
                if (widx == 6'(`PIRQ_IDX_EN0 + r)) begin
                    s_next.enables[16*r +: 16] = pwdata[15:0]; // [R14] [R12] [R13]
                end
            end
            for (int r = 0; r < `PIRQ_NUM_PRIO_REGS; r++) begin
                if (widx == 6'(`PIRQ_IDX_PRIO0 + r)) begin
                    for (int j = 0; j < `PIRQ_PRIO_PER_REG; j++) begin
                        s_next.prio[`PIRQ_PRIO_PER_REG*r + j] = pwdata[4*j +: 3]; // [R3]
                    end
                end
            end
        end

        // hardware sets win over a software clear in the same cycle
        s_next.flags      = (s_next.flags | set_vec) & IMPL_MASK; // [R1]
        s_next.enables    = s_next.enables & IMPL_MASK; // [R15] [R16]
        s_next.trap_flags = s_next.trap_flags | trap_event; // [R9]

        // latch follows the winner each cycle; zero when nothing is eligible
        s_next.vector_number = found ? best_v : 7'h00; // [R4]
        s_next.latched_level = found ? {1'b0, best_p} : 4'h0; // [R5]
        s_next.core_req      = want_req; // [R17]

        // summary events
        events = '0;
        events[`PIRQ_EV_REQ_BIT]  = want_req & ~s_reg.core_req;
        events[`PIRQ_EV_LOST_BIT] = |(set_vec & s_reg.flags);
        if (wr_en && (widx == `PIRQ_IDX_IRQ_CLR)) begin
            s_next.irq_stat = s_reg.irq_stat & ~pwdata[`PIRQ_NUM_EV-1:0];
        end
        s_next.irq_stat = s_next.irq_stat | events;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0; // [R14]
        end else begin
            s_reg <= s_next;
        end
    end

endmodule
`default_nettype wire

/* File: hw/pirq_consts.svh */
// register indices, field positions and masks of the interrupt controller
`ifndef PIRQ_CONSTS_SVH
`define PIRQ_CONSTS_SVH

`define PIRQ_NUM_SRC        96
`define PIRQ_NUM_FLAG_REGS  6
`define PIRQ_NUM_PRIO_REGS  24
`define PIRQ_PRIO_PER_REG   4

// word indices; byte address is four times the index
`define PIRQ_IDX_GIC1       6'h00
`define PIRQ_IDX_GIC2       6'h01
`define PIRQ_IDX_FLAG0      6'h02
`define PIRQ_IDX_EN0        6'h08
`define PIRQ_IDX_PRIO0      6'h0e
`define PIRQ_IDX_VLATCH     6'h26
`define PIRQ_IDX_ALU_STAT   6'h27
`define PIRQ_IDX_CORE_CTRL  6'h28
`define PIRQ_IDX_IRQ_STAT   6'h29
`define PIRQ_IDX_IRQ_CLR    6'h2a
`define PIRQ_IDX_IRQ_EN     6'h2b

// global control 1 and 2 fields
`define PIRQ_GIC1_NEST_BIT  15
`define PIRQ_GIC1_TRAP_LSB  1
`define PIRQ_NUM_TRAPS      4
`define PIRQ_GIC2_ALT_BIT   15
`define PIRQ_NUM_EXT        3

// cpu level fields
`define PIRQ_ALU_IPL_LSB    5
`define PIRQ_CORE_CPU_PRIORITY_MSB_BIT  3
`define PIRQ_VL_LVL_LSB     8

// vectors of the external lines
`define PIRQ_VEC_EXT0       0
`define PIRQ_VEC_EXT1       20
`define PIRQ_VEC_EXT2       29

// implemented bits of interrupt_enable_1, full and small variants
`define PIRQ_EN1_FULL_MASK  16'hea1f
`define PIRQ_EN1_SMALL_MASK 16'h201f
`define PIRQ_FULL_MASK      16'hffff

// event bits of the summary interrupt
`define PIRQ_EV_REQ_BIT     0
`define PIRQ_EV_LOST_BIT    1
`define PIRQ_NUM_EV         2

`endif

/* File: hw/pirq_pkg.sv */
// types of the prioritized interrupt controller
`include "pirq_consts.svh"

package pirq_pkg;

    typedef logic [2:0] pirq_prio_t;

    // everything presented to the processor core
    typedef struct packed {
        logic       req;
        logic [6:0] vector_number;
        logic [3:0] latched_level;
        logic       alt_vector_sel;
    } pirq_core_t;

    // whole state of the controller
    typedef struct packed {
        logic [`PIRQ_NUM_SRC-1:0]              flags;
        logic [`PIRQ_NUM_SRC-1:0]              enables;
        logic [`PIRQ_NUM_SRC-1:0][2:0]         prio;
        logic                                  nesting_disable;
        logic [`PIRQ_NUM_TRAPS-1:0]            trap_flags;
        logic                                  alternate_vector_table;
        logic [`PIRQ_NUM_EXT-1:0]              ext_falling;
        logic [2:0]                            cpu_priority_level;
        logic [6:0]                            vector_number;
        logic [3:0]                            latched_level;
        logic                                  core_req;
        logic [`PIRQ_NUM_EV-1:0]               irq_stat;
        logic [`PIRQ_NUM_EV-1:0]               irq_en;
        logic [`PIRQ_NUM_EXT-1:0]              ext_s1;
        logic [`PIRQ_NUM_EXT-1:0]              ext_s2;
        logic [`PIRQ_NUM_EXT-1:0]              ext_prev;
        logic [31:0]                           prdata;
    } pirq_state_t;

endpackage

/* File: bench/pirq_props.sv */
// port assertions of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "pirq_consts.svh"
module pirq_props (
    // clock and reset
    input wire logic                       clk_sys,
    input wire logic                       rst_n,
    // apb
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [11:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic                       pready,
    input wire logic [31:0]                prdata,
    input wire logic                       pslverr,
    // sources and core
    input wire logic [`PIRQ_NUM_SRC-1:0]   periph_req,
    input wire logic [`PIRQ_NUM_EXT-1:0]   ext_line,
    input wire logic [`PIRQ_NUM_TRAPS-1:0] trap_event,
    input wire logic                       cpu_priority_msb,
    input wire pirq_pkg::pirq_core_t       core,
    input wire logic                       irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic acc;
    assign acc = psel && penable;
    a_zero_wait: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && paddr[11:8] != 4'h0 |-> pslverr
        && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    a_en1_gaps: assert property (acc && !pwrite && paddr == 12'h024 |->
        (prdata[15:0] & ~16'hea1f) == 16'h0) else $error("gap bits read set");
    a_msb_view: assert property (psel && !penable && !pwrite && paddr == 12'h0a0
        |=> prdata[3] == $past(cpu_priority_msb)) else $error("level msb read wrong");
    a_vlatch_view: assert property (acc && !pwrite && paddr == 12'h098 |->
        prdata[11:0] == {$past(core.latched_level), 1'b0, $past(core.vector_number)})
        else $error("vector latch read differs from core outputs");
    a_req_level: assert property (core.req |-> core.latched_level inside {[4'h1:4'h7]})
        else $error("request with impossible level");
    a_msb_blocks: assert property (cpu_priority_msb [*3] |-> !core.req)
        else $error("request beat a level of eight");
    c_req: cover property (core.req);
    c_err: cover property (pslverr);
    c_irq: cover property (irq);
endmodule
bind pirq_top pirq_props i_props (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .periph_req(periph_req), .ext_line(ext_line),
    .trap_event(trap_event), .cpu_priority_msb(cpu_priority_msb), .core(core), .irq(irq));
`default_nettype wire

/* File: bench/pirq_src_model.sv */
// far side model: peripheral request lines, external pins, core level bit
`timescale 1ns/1ps
`default_nettype none
`include "pirq_consts.svh"
module pirq_src_model (
    // clock
    input  wire logic                      clk_sys,
    // toward the controller
    output var logic [`PIRQ_NUM_SRC-1:0]   periph_req,
    output var logic [`PIRQ_NUM_EXT-1:0]   ext_line,
    output var logic [`PIRQ_NUM_TRAPS-1:0] trap_event,
    output var logic                       cpu_priority_msb
);
    initial begin
        periph_req = '0;
        ext_line = 3'h0;
        trap_event = 4'h0;
        cpu_priority_msb = 1'b0;
    end
    // a peripheral event is a single-cycle pulse on its own line
    task automatic fire(input logic [6:0] v);
        @(posedge clk_sys);
        periph_req[v] <= 1'b1;
        @(posedge clk_sys);
        periph_req[v] <= 1'b0;
    endtask
    // pins are held, the controller sees only the edge
    task automatic ext(input logic [1:0] i, input logic v);
        @(posedge clk_sys);
        ext_line[i] <= v;
    endtask
    // a trap is a single-cycle pulse; the flag it sets stays until software clears it
    task automatic trap(input logic [3:0] v);
        @(posedge clk_sys);
        trap_event <= v;
        @(posedge clk_sys);
        trap_event <= 4'h0;
    endtask
    // the core owns this bit; software can only read it
    task automatic msb(input logic v);
        @(posedge clk_sys);
        cpu_priority_msb <= v;
    endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "pirq_consts.svh"
module testbench;
    logic                       clk_sys;
    logic                       rst_n;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [11:0]                paddr;
    logic [31:0]                pwdata;
    logic                       pready;
    logic [31:0]                prdata;
    logic                       pslverr;
    logic [`PIRQ_NUM_SRC-1:0]   periph_req;
    logic [`PIRQ_NUM_EXT-1:0]   ext_line;
    logic [`PIRQ_NUM_TRAPS-1:0] trap_event;
    logic                       cpu_priority_msb;
    pirq_pkg::pirq_core_t       core;
    logic                       irq;
    logic [31:0]                rdv;
    logic                       erv;
    int                         err_total;
    int                         samples_checked;
    pirq_top #(.SMALL_VARIANT(1'b0)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .periph_req(periph_req), .ext_line(ext_line),
        .trap_event(trap_event), .cpu_priority_msb(cpu_priority_msb), .core(core), .irq(irq));
    pirq_src_model i_src (.clk_sys(clk_sys), .periph_req(periph_req), .ext_line(ext_line),
        .trap_event(trap_event), .cpu_priority_msb(cpu_priority_msb));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task print_verdict;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the master waits up to 20 cycles for pready, then ends the run as failed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            print_verdict;
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task core_is(input logic r, input logic [6:0] v, input logic [3:0] l);
        chk({20'h0, core.req, core.vector_number, core.latched_level}, {20'h0, r, v, l});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_en1;
        rc(12'h024, 32'h0);
        wr(12'h024, 32'hffff);
        rc(12'h024, 32'hea1f);
        wr(12'h024, 32'h0);
        rc(12'h024, 32'h0);
    endtask
    task t_err;
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, erv}, 32'h1);
        chk(rdv, 32'h0);
    endtask
    task t_prio;
        wr(12'h020, 32'h00a0);
        wr(12'h03c, 32'h6030);
        i_src.fire(7'h05);
        i_src.fire(7'h07);
        i_src.ext(2'h0, 1'b1);
        cyc(6);
        core_is(1'b1, 7'h07, 4'h6);
        rc(12'h098, 32'h0607);
        rc(12'h008, 32'h00a1);
        // the pin is still high: a level would set the flag again
        wr(12'h008, 32'h0021);
        cyc(3);
        core_is(1'b1, 7'h05, 4'h3);
    endtask
    task t_irq;
        i_src.fire(7'h05);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        rc(12'h0a4, 32'h3);
        wr(12'h0ac, 32'h3);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(12'h0a8, 32'h3);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        rc(12'h0a4, 32'h0);
    endtask
    task t_ipl;
        wr(12'h09c, 32'h0060);
        cyc(3);
        chk({31'h0, core.req}, 32'h0);
        wr(12'h09c, 32'h0040);
        cyc(3);
        chk({31'h0, core.req}, 32'h1);
        rc(12'h09c, 32'h0040);
        wr(12'h020, 32'h0);
        cyc(3);
        chk({31'h0, core.req}, 32'h0);
        wr(12'h09c, 32'h0);
    endtask
    task t_msb;
        i_src.msb(1'b1);
        wr(12'h0a0, 32'h0);
        rc(12'h0a0, 32'h8);
    endtask
    task t_glob;
        wr(12'h008, 32'h0);
        wr(12'h004, 32'h8001);
        cyc(1);
        chk({31'h0, core.alt_vector_sel}, 32'h1);
        // line 0 now reacts to the falling edge only
        i_src.ext(2'h0, 1'b0);
        cyc(6);
        rc(12'h008, 32'h1);
        rc(12'h004, 32'h8001);
        wr(12'h000, 32'h8000);
        i_src.trap(4'h2);
        cyc(2);
        rc(12'h000, 32'h8004);
        i_src.msb(1'b0);
        wr(12'h038, 32'h5);
        wr(12'h020, 32'h1);
        wr(12'h09c, 32'h40);
        cyc(3);
        chk({31'h0, core.req}, 32'h0);
        wr(12'h000, 32'h0);
        cyc(3);
        core_is(1'b1, 7'h00, 4'h5);
    endtask
    initial begin
        err_total = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_en1;
        t_err;
        t_prio;
        t_irq;
        t_ipl;
        t_msb;
        t_glob;
        print_verdict;
    end
endmodule
`default_nettype wire
